// ### hw/bcd_dec_pkg.sv
// Constants for the decimal adjust and decrement execution block
`default_nettype none
package bcd_dec_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] OPERAND_OFF = 8'h04;
   localparam logic [7:0] ACCUM_OFF = 8'h08;
   localparam logic [7:0] FLAGS_OFF = 8'h0C;
   localparam logic [7:0] BANK_OFF = 8'h10;
   localparam logic [7:0] INDEX_OFF = 8'h14;
   localparam logic [7:0] MEM_ADDR_OFF = 8'h18;
   localparam logic [7:0] MEM_DATA_OFF = 8'h1C;
   // Control register fields
   localparam int CTRL_ADJUST_BIT = 0;
   localparam int CTRL_DECR_BIT = 1;
   localparam int CTRL_BUSY_BIT = 0;
   localparam int CTRL_PEND_BIT = 1;
   // Operand register fields
   localparam int OPND_DEST_BIT = 8;
   localparam int OPND_BANKSEL_BIT = 9;
   localparam int OPND_EXT_BIT = 10;
   // Flag register fields
   localparam int FLAG_C_BIT = 0;
   localparam int FLAG_DC_BIT = 1;
   localparam int FLAG_Z_BIT = 2;
   localparam int FLAG_OV_BIT = 3;
   localparam int FLAG_N_BIT = 4;
   localparam int FLAG_W = 5;
   // Reset values
   localparam logic [7:0] ACCUM_RST = 8'h00;
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam logic [10:0] OPERAND_RST = 11'h300;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic [11:0] INDEX_RST = 12'h000;
   // Arithmetic figures
   localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
   localparam logic [3:0] BCD_CORRECTION = 4'h6;
   localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   // One instruction cycle is four quarter phases
   localparam logic [1:0] QUARTER_LAST = 2'h3;
   typedef enum logic [1:0]
   {
      OP_NONE = 2'b00,
      OP_ADJUST = 2'b01,
      OP_DECR = 2'b10
   } op_type;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_DECODE = 3'b001,
      ST_READ = 3'b010,
      ST_PROCESS = 3'b011,
      ST_WRITE = 3'b100
   } state_type;
endpackage
`default_nettype wire

// ### hw/bcd_dec_alu.sv
// Combinational arithmetic for decimal adjust and file decrement
`timescale 1ns/1ns
`default_nettype none
module bcd_dec_alu
(
   input wire bcd_dec_pkg::op_type op_i,
   input wire logic [7:0] accum_i,
   input wire logic [7:0] operand_i,
   input wire logic carry_i,
   input wire logic nibble_overflow_flag_i,
   output logic [7:0] result_o,
   output logic [bcd_dec_pkg::FLAG_W-1:0] flags_o
);
   logic lo_adj;
   logic hi_adj;
   logic [8:0] lo_sum;
   logic [8:0] full_sum;
   logic [7:0] dec_res;

   always_comb
   begin
      flags_o = '0;
      // Low digit; its carry ripples into the high digit before that test
      lo_adj = (accum_i[3:0] > bcd_dec_pkg::BCD_MAX_DIGIT)
         | nibble_overflow_flag_i;
      lo_sum = {1'b0, accum_i}
         + {5'h00, (lo_adj ? bcd_dec_pkg::BCD_CORRECTION : 4'h0)};
      hi_adj = (lo_sum[8:4] > {1'b0, bcd_dec_pkg::BCD_MAX_DIGIT})
         | carry_i;
      full_sum = lo_sum
         + {1'b0, (hi_adj ? bcd_dec_pkg::BCD_CORRECTION : 4'h0), 4'h0};
      dec_res = operand_i - 8'h01;
      if (op_i == bcd_dec_pkg::OP_DECR)
      begin
         result_o = dec_res;
         // Carry and digit carry mean no borrow
         flags_o[bcd_dec_pkg::FLAG_C_BIT] = (operand_i != 8'h00);
         flags_o[bcd_dec_pkg::FLAG_DC_BIT] = (operand_i[3:0] != 4'h0);
         flags_o[bcd_dec_pkg::FLAG_Z_BIT] = (dec_res == 8'h00);
         flags_o[bcd_dec_pkg::FLAG_OV_BIT] = (operand_i == 8'h80);
         flags_o[bcd_dec_pkg::FLAG_N_BIT] = dec_res[7];
      end
      else
      begin
         result_o = full_sum[7:0];
         flags_o[bcd_dec_pkg::FLAG_C_BIT] = carry_i | hi_adj
            | full_sum[8];
      end
   end
endmodule
`default_nettype wire

// ### hw/bcd_dec_exec.sv
// Decimal adjust and file decrement datapath with a Wishbone slave
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Low digit above nine or digit carry set gets six added, else unchanged.
// - Adjust takes one cycle: decode, read accumulator, compute, write back.
// - Decrement subtracts one from the addressed file byte, 8-bit result.
// - Destination bit 0 writes the result to the accumulator only.
// - Destination bit 1, the default, writes the result back to the file.
// - Bank bit 0 resolves the address inside the quick bank.
// - Bank bit 1, the default, uses the bank pointer for the bank.
// - Bank bit 0 with extended set and address up to 95 is indexed.
module bcd_dec_exec
#(
   parameter int ADDR_W = 12
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   if (ADDR_W != 12)
   begin
      $error("ADDR_W must be 12: bank pointer plus 8-bit offset");
   end

   ////////////////////////////////////////////////////////////////////////
   // Storage and state
   logic [7:0] mem [0:(1<<ADDR_W)-1];
   logic [7:0] accum_reg;
   logic [bcd_dec_pkg::FLAG_W-1:0] flags_reg;
   logic [10:0] operand_reg;
   logic [3:0] bank_select_pointer_reg;
   logic [11:0] index_base_reg;
   logic [11:0] mem_addr_reg;
   logic [1:0] quarter_reg;
   bcd_dec_pkg::op_type pend_op_reg;
   bcd_dec_pkg::op_type op_reg;
   bcd_dec_pkg::state_type state_reg;
   bcd_dec_pkg::state_type state_next;
   logic [11:0] eff_addr_reg;
   logic [11:0] eff_addr_next;
   logic [7:0] opnd_data_reg;
   logic [7:0] accum_snap_reg;
   logic [7:0] result_reg;
   logic [bcd_dec_pkg::FLAG_W-1:0] flags_res_reg;
   logic [7:0] alu_result;
   logic [bcd_dec_pkg::FLAG_W-1:0] alu_flags;
   logic ack_reg;
   logic [31:0] rdata_next;
   logic bus_req;
   logic bus_wr;
   logic busy;
   logic exec_write;
   logic to_file;
   logic [7:0] file_addr;
   logic [31:0] operand_wr;
   logic [31:0] index_wr;
   logic [31:0] mem_addr_wr;

   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
   // Writes land at the edge where ack is seen high, as the master expects
   assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
   assign busy = (state_reg != bcd_dec_pkg::ST_IDLE);
   assign exec_write = (state_reg == bcd_dec_pkg::ST_WRITE);
   assign to_file = (op_reg == bcd_dec_pkg::OP_DECR)
      & operand_reg[bcd_dec_pkg::OPND_DEST_BIT];
   assign file_addr = operand_reg[7:0];
   assign operand_wr = merge({21'h0, operand_reg}, wb_dat_i, wb_sel_i);
   assign index_wr = merge({20'h0, index_base_reg}, wb_dat_i, wb_sel_i);
   assign mem_addr_wr = merge({20'h0, mem_addr_reg}, wb_dat_i, wb_sel_i);

   // Merge byte lanes of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            res[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Quarter phase counter, free running
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         quarter_reg <= 2'h0;
      else
         quarter_reg <= quarter_reg + 2'h1;
   end

   // A started operation waits for the next first quarter
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pend_op_reg <= bcd_dec_pkg::OP_NONE;
      else if (bus_wr && wb_adr_i == bcd_dec_pkg::CTRL_OFF && wb_sel_i[0])
      begin
         if (wb_dat_i[bcd_dec_pkg::CTRL_ADJUST_BIT])
            pend_op_reg <= bcd_dec_pkg::OP_ADJUST;
         else if (wb_dat_i[bcd_dec_pkg::CTRL_DECR_BIT])
            pend_op_reg <= bcd_dec_pkg::OP_DECR;
      end
      else if (!busy && quarter_reg == bcd_dec_pkg::QUARTER_LAST)
         pend_op_reg <= bcd_dec_pkg::OP_NONE;
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction sequencer: one state per quarter
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         bcd_dec_pkg::ST_IDLE:
         begin
            if (pend_op_reg != bcd_dec_pkg::OP_NONE
               && quarter_reg == bcd_dec_pkg::QUARTER_LAST)
               state_next = bcd_dec_pkg::ST_DECODE;
         end
         bcd_dec_pkg::ST_DECODE:
            state_next = bcd_dec_pkg::ST_READ;
         bcd_dec_pkg::ST_READ:
            state_next = bcd_dec_pkg::ST_PROCESS;
         bcd_dec_pkg::ST_PROCESS:
            state_next = bcd_dec_pkg::ST_WRITE;
         bcd_dec_pkg::ST_WRITE:
            state_next = bcd_dec_pkg::ST_IDLE;
         default:
            state_next = bcd_dec_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= bcd_dec_pkg::ST_IDLE;
         op_reg <= bcd_dec_pkg::OP_NONE;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == bcd_dec_pkg::ST_IDLE
            && state_next == bcd_dec_pkg::ST_DECODE)
            op_reg <= pend_op_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operand address formed during decode
   always_comb
   begin
      if (operand_reg[bcd_dec_pkg::OPND_BANKSEL_BIT])
         eff_addr_next = {bank_select_pointer_reg, file_addr};
      else if (operand_reg[bcd_dec_pkg::OPND_EXT_BIT]
         && file_addr <= bcd_dec_pkg::ACCESS_SPLIT)
         eff_addr_next = index_base_reg + {4'h0, file_addr};
      else if (file_addr <= bcd_dec_pkg::ACCESS_SPLIT)
         eff_addr_next = {4'h0, file_addr};
      else
         eff_addr_next = {bcd_dec_pkg::ACCESS_HIGH_BANK, file_addr};
   end

   // Read in second quarter, compute in third; operands held still
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         eff_addr_reg <= 12'h000;
         opnd_data_reg <= 8'h00;
         accum_snap_reg <= 8'h00;
         result_reg <= 8'h00;
         flags_res_reg <= '0;
      end
      else
      begin
         if (state_reg == bcd_dec_pkg::ST_DECODE)
            eff_addr_reg <= eff_addr_next;
         if (state_reg == bcd_dec_pkg::ST_READ)
         begin
            accum_snap_reg <= accum_reg;
            opnd_data_reg <= mem[eff_addr_reg];
         end
         if (state_reg == bcd_dec_pkg::ST_PROCESS)
         begin
            result_reg <= alu_result;
            flags_res_reg <= alu_flags;
         end
      end
   end

   bcd_dec_alu bcd_dec_alu_i
   (
      .op_i(op_reg),
      .accum_i(accum_snap_reg),
      .operand_i(opnd_data_reg),
      .carry_i(flags_reg[bcd_dec_pkg::FLAG_C_BIT]),
      .nibble_overflow_flag_i(flags_reg[bcd_dec_pkg::FLAG_DC_BIT]),
      .result_o(alu_result),
      .flags_o(alu_flags)
   );

   ////////////////////////////////////////////////////////////////////////
   // Accumulator and flags; write-back in fourth quarter beats the bus
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         accum_reg <= bcd_dec_pkg::ACCUM_RST;
      else if (exec_write && !to_file)
         accum_reg <= result_reg;
      else if (bus_wr && wb_adr_i == bcd_dec_pkg::ACCUM_OFF && wb_sel_i[0])
         accum_reg <= wb_dat_i[7:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         flags_reg <= bcd_dec_pkg::FLAGS_RST;
      else if (exec_write && op_reg == bcd_dec_pkg::OP_DECR)
         flags_reg <= flags_res_reg;
      else if (exec_write)
         flags_reg[bcd_dec_pkg::FLAG_C_BIT] <=
            flags_res_reg[bcd_dec_pkg::FLAG_C_BIT];
      else if (bus_wr && wb_adr_i == bcd_dec_pkg::FLAGS_OFF && wb_sel_i[0])
         flags_reg <= wb_dat_i[bcd_dec_pkg::FLAG_W-1:0];
   end

   // Data memory: file write-back wins over a window write
   always_ff @(posedge clk_i)
   begin
      if (exec_write && to_file)
         mem[eff_addr_reg] <= result_reg;
      else if (bus_wr && wb_adr_i == bcd_dec_pkg::MEM_DATA_OFF
         && wb_sel_i[0])
         mem[mem_addr_reg] <= wb_dat_i[7:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers; operand changes while busy are held off
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         operand_reg <= bcd_dec_pkg::OPERAND_RST;
         bank_select_pointer_reg <= bcd_dec_pkg::BANK_RST;
         index_base_reg <= bcd_dec_pkg::INDEX_RST;
         mem_addr_reg <= 12'h000;
      end
      else if (bus_wr)
      begin
         case (wb_adr_i)
            bcd_dec_pkg::OPERAND_OFF:
            begin
               if (!busy)
                  operand_reg <= operand_wr[10:0];
            end
            bcd_dec_pkg::BANK_OFF:
            begin
               if (!busy && wb_sel_i[0])
                  bank_select_pointer_reg <= wb_dat_i[3:0];
            end
            bcd_dec_pkg::INDEX_OFF:
            begin
               if (!busy)
                  index_base_reg <= index_wr[11:0];
            end
            bcd_dec_pkg::MEM_ADDR_OFF:
               mem_addr_reg <= mem_addr_wr[11:0];
            default:
               mem_addr_reg <= mem_addr_reg;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wishbone read mux; unmapped addresses read zero and still ack
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      case (wb_adr_i)
         bcd_dec_pkg::CTRL_OFF:
         begin
            rdata_next[bcd_dec_pkg::CTRL_BUSY_BIT] = busy;
            rdata_next[bcd_dec_pkg::CTRL_PEND_BIT] =
               (pend_op_reg != bcd_dec_pkg::OP_NONE);
         end
         bcd_dec_pkg::OPERAND_OFF:
            rdata_next[10:0] = operand_reg;
         bcd_dec_pkg::ACCUM_OFF:
            rdata_next[7:0] = accum_reg;
         bcd_dec_pkg::FLAGS_OFF:
            rdata_next[bcd_dec_pkg::FLAG_W-1:0] = flags_reg;
         bcd_dec_pkg::BANK_OFF:
            rdata_next[3:0] = bank_select_pointer_reg;
         bcd_dec_pkg::INDEX_OFF:
            rdata_next[11:0] = index_base_reg;
         bcd_dec_pkg::MEM_ADDR_OFF:
            rdata_next[11:0] = mem_addr_reg;
         bcd_dec_pkg::MEM_DATA_OFF:
            rdata_next[7:0] = mem[mem_addr_reg];
         default:
            rdata_next = 32'h0000_0000;
      endcase
   end

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= bus_req;
         if (bus_req && !wb_we_i)
            wb_dat_o <= rdata_next;
      end
   end

   assign wb_ack_o = ack_reg;
endmodule
`default_nettype wire

// ### tb/bcd_dec_exec_sva.sv
// Bus protocol checker for the adjust and decrement block
`timescale 1ns/1ns
`default_nettype none
module bcd_dec_exec_sva
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence rd(logic [7:0] a);
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == a;
   endsequence
   sequence rd_hole;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
         && (wb_adr_i[1:0] != 2'h0 || wb_adr_i > 8'h1C);
   endsequence
   ack_follows_req_a: assert property (taken |=> wb_ack_o)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property
      (!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> !wb_ack_o)
      else $error("ack without request");
   dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
      else $error("read data moved without ack");
   accum_width_a: assert property
      (rd(bcd_dec_pkg::ACCUM_OFF) |=> wb_dat_o[31:8] == 24'h0)
      else $error("accumulator read wider than a byte");
   flags_width_a: assert property
      (rd(bcd_dec_pkg::FLAGS_OFF) |=> wb_dat_o[31:5] == 27'h0)
      else $error("flags read wider than five bits");
   ctrl_width_a: assert property
      (rd(bcd_dec_pkg::CTRL_OFF) |=> wb_dat_o[31:2] == 30'h0)
      else $error("status read wider than two bits");
   hole_zero_a: assert property (rd_hole |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   reset_quiet_a: assert property (disable iff (1'b0)
      rst_i |=> !wb_ack_o && wb_dat_o == 32'h0)
      else $error("bus outputs not cleared by reset");
endmodule
bind bcd_dec_exec bcd_dec_exec_sva bcd_dec_exec_sva_i
(
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);
`default_nettype wire

// ### tb/bcd_dec_exec_test.sv
// Self-checking bench for the adjust and decrement block
`timescale 1ns/1ns
`default_nettype none
module bcd_dec_exec_test;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd_data;
   int num_errors = 0;
   int checks_done = 0;
   logic [31:0] adj_in [6] = '{32'hA5, 32'hCE, 32'h09, 32'h12, 32'h9A, 32'h45};
   logic [31:0] adj_fl [6] = '{32'h00, 32'h00, 32'h02, 32'h00, 32'h00, 32'h01};
   logic [31:0] adj_out [6] = '{32'h05, 32'h34, 32'h0F, 32'h12, 32'h00, 32'hA5};
   logic [31:0] adj_fo [6] = '{32'h01, 32'h01, 32'h02, 32'h00, 32'h01, 32'h01};
   // Operand, pointer, index, memory address, data in and out, acc, flags
   logic [31:0] dc_op [5] = '{32'h310, 32'h020, 32'h180, 32'h55F, 32'h560};
   logic [31:0] dc_pt [5] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h3};
   logic [31:0] dc_ix [5] = '{32'h0, 32'h0, 32'h0, 32'h200, 32'h200};
   logic [31:0] dc_ma [5] = '{32'h310, 32'h020, 32'hF80, 32'h25F, 32'hF60};
   logic [31:0] dc_mi [5] = '{32'h01, 32'h00, 32'h80, 32'h10, 32'h05};
   logic [31:0] dc_mo [5] = '{32'h00, 32'h00, 32'h7F, 32'h0F, 32'h04};
   logic [31:0] dc_ac [5] = '{32'h55, 32'hFF, 32'h55, 32'h55, 32'h55};
   logic [31:0] dc_fl [5] = '{32'h07, 32'h10, 32'h09, 32'h01, 32'h03};
   bcd_dec_exec bcd_dec_exec_i
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
   );
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Entered just after an edge; leaves the bus idle for one cycle
   task automatic wb_cycle(input logic we, input logic [7:0] adr,
      input logic [31:0] dat);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= dat;
      // Only the watchdog ends a wait for ack
      do
      begin
         @(posedge clk_i);
      end
      while (wb_ack_o !== 1'b1);
      rd_data = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd_chk(input string name, input logic [7:0] adr,
      input logic [31:0] exp);
      wb_cycle(1'b0, adr, 32'h0);
      check(name, rd_data, exp);
   endtask
   // Polls busy and pending; the loop stops at eight polls, and more than four polls fails the check
   task automatic run_op(input logic [31:0] start);
      int n;
      wb_cycle(1'b1, bcd_dec_pkg::CTRL_OFF, start);
      n = 0;
      do
      begin
         wb_cycle(1'b0, bcd_dec_pkg::CTRL_OFF, 32'h0);
         n++;
      end
      while (rd_data[1:0] !== 2'h0 && n < 8);
      check("ctrl idle", rd_data, 32'h0);
      check("poll count", 32'(n > 4), 32'h0);
   endtask
   initial
   begin
      #200000;
      num_errors++;
      summarize();
   end
   initial
   begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk("operand", bcd_dec_pkg::OPERAND_OFF, 32'h300);
      rd_chk("accum", bcd_dec_pkg::ACCUM_OFF, 32'h0);
      rd_chk("flags", bcd_dec_pkg::FLAGS_OFF, 32'h0);
      rd_chk("bank", bcd_dec_pkg::BANK_OFF, 32'h0);
      rd_chk("unmapped", 8'h20, 32'h0);
      for (int i = 0; i < 6; i++)
      begin
         wb_cycle(1'b1, bcd_dec_pkg::ACCUM_OFF, adj_in[i]);
         wb_cycle(1'b1, bcd_dec_pkg::FLAGS_OFF, adj_fl[i]);
         run_op(32'h1);
         rd_chk("adj acc", bcd_dec_pkg::ACCUM_OFF, adj_out[i]);
         rd_chk("adj flags", bcd_dec_pkg::FLAGS_OFF, adj_fo[i]);
      end
      for (int i = 0; i < 5; i++)
      begin
         wb_cycle(1'b1, bcd_dec_pkg::BANK_OFF, dc_pt[i]);
         wb_cycle(1'b1, bcd_dec_pkg::INDEX_OFF, dc_ix[i]);
         wb_cycle(1'b1, bcd_dec_pkg::OPERAND_OFF, dc_op[i]);
         wb_cycle(1'b1, bcd_dec_pkg::ACCUM_OFF, 32'h55);
         wb_cycle(1'b1, bcd_dec_pkg::MEM_ADDR_OFF, dc_ma[i]);
         wb_cycle(1'b1, bcd_dec_pkg::MEM_DATA_OFF, dc_mi[i]);
         run_op(32'h2);
         rd_chk("dec acc", bcd_dec_pkg::ACCUM_OFF, dc_ac[i]);
         rd_chk("dec mem", bcd_dec_pkg::MEM_DATA_OFF, dc_mo[i]);
         rd_chk("dec flags", bcd_dec_pkg::FLAGS_OFF, dc_fl[i]);
      end
      // Banked access through another pointer value, result to the file
      wb_cycle(1'b1, bcd_dec_pkg::BANK_OFF, 32'h5);
      wb_cycle(1'b1, bcd_dec_pkg::OPERAND_OFF, 32'h310);
      wb_cycle(1'b1, bcd_dec_pkg::MEM_ADDR_OFF, 32'h510);
      wb_cycle(1'b1, bcd_dec_pkg::MEM_DATA_OFF, 32'h33);
      run_op(32'h2);
      rd_chk("bank dec", bcd_dec_pkg::MEM_DATA_OFF, 32'h32);
      rd_chk("file dest acc", bcd_dec_pkg::ACCUM_OFF, 32'h55);
      wb_cycle(1'b1, bcd_dec_pkg::MEM_ADDR_OFF, 32'h310);
      rd_chk("other bank", bcd_dec_pkg::MEM_DATA_OFF, 32'h00);
      // Indexed access: quick bank byte 020 holds 00, indexed 220 holds 40
      wb_cycle(1'b1, bcd_dec_pkg::OPERAND_OFF, 32'h420);
      wb_cycle(1'b1, bcd_dec_pkg::MEM_ADDR_OFF, 32'h220);
      wb_cycle(1'b1, bcd_dec_pkg::MEM_DATA_OFF, 32'h40);
      run_op(32'h2);
      rd_chk("indexed dec", bcd_dec_pkg::ACCUM_OFF, 32'h3F);
      rd_chk("indexed mem", bcd_dec_pkg::MEM_DATA_OFF, 32'h40);
      summarize();
   end
endmodule
`default_nettype wire
